// ==== hdl/fifo_defines.svh ====
// Purpose: constants for the flagged port-to-port queue
// Assumes: one clock drives both ports
// Notes: widths and depth feed module parameter defaults
`ifndef FIFO_DEFINES_SVH
`define FIFO_DEFINES_SVH

// ==========================================================
// geometry
`define FIFO_DEPTH 256
`define FIFO_ADDR_W 8
`define FIFO_DATA_W 36

// ==========================================================
// reset values
`define FIFO_PTR_RST '0
`define FIFO_OUT_RST '0
`define FIFO_OREADY_RST 1'h0
`define FIFO_ARMED_RST 1'h1

`endif

// ==== hdl/fifo_pkg.sv ====
// Purpose: shared types for the flagged port-to-port queue
// Assumes: nothing beyond the defines header
// Notes: no constants here, only types
package fifo_pkg;

  // ==========================================================
  // per-port control group
  typedef struct packed {
    logic select_n; // active-low chip select
    logic dir;      // write/read select
    logic strobe;   // transfer enable
    logic mail_sel; // mailbox select
  } port_ctrl_t;

  // ==========================================================
  // output timing mode, one-hot
  typedef enum logic [1:0] {
    MODE_STANDARD     = 2'h1,
    MODE_FALL_THROUGH = 2'h2
  } mode_t;

endpackage

// ==== hdl/dual_clock_fifo_port_flags.sv ====
// Purpose: port A to port B queue with four synchronised flags
// Assumes: both port clocks are the single mclk
// Notes: pointers still cross through gray two-stage synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defines.svh"

module dual_clock_fifo_port_flags #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int ADDR_W = `FIFO_ADDR_W,
  parameter int DATA_W = `FIFO_DATA_W
) (
  input wire logic mclk, // clock for both ports
  input wire logic reset_n, // synchronous, active low
  input wire fifo_pkg::port_ctrl_t port_a_ctrl, // port A controls
  input wire logic [DATA_W-1:0] a_data_in, // port A data pins in
  output logic [DATA_W-1:0] a_data_out, // port A data pins out
  output logic a_data_oe, // port A drive enable
  input wire fifo_pkg::port_ctrl_t port_b_ctrl, // port B controls
  output logic [DATA_W-1:0] b_data_out, // output register
  output logic b_data_oe, // port B drive enable
  input wire logic mode_endian_select, // low selects fall-through
  input wire logic [ADDR_W:0] almost_empty_offset, // X
  input wire logic [ADDR_W:0] almost_full_offset, // Y
  output logic full_inready_flag, // room for a word
  output logic almost_full_flag, // low when nearly full
  output logic empty_outready_flag, // data ready for port B
  output logic almost_empty_flag // low when nearly empty
);

  // ==========================================================
  // gray helpers
  function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [ADDR_W:0] from_gray(
    input logic [ADDR_W:0] g
  );
    logic [ADDR_W:0] b;
    b = g;
    for (int i = ADDR_W - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  localparam logic [ADDR_W:0] DEPTH_W = (ADDR_W + 1)'(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W:0] wr_ptr_q, rd_ptr_q, wr_gray_q, rd_gray_q;
  logic [ADDR_W:0] wr_gray_s1_q, wr_gray_s2_q;
  logic [ADDR_W:0] rd_gray_s1_q, rd_gray_s2_q;
  logic [ADDR_W:0] wr_seen, rd_seen, cnt_a, cnt_b, af_level;
  logic [DATA_W-1:0] out_q;
  logic oready_q, oready_d, load, mem_has;
  logic wr_try, wr_en, rd_try, fall_through_mode, mode_armed_q;
  fifo_pkg::mode_t mode_q;

  // ==========================================================
  // mode strap, caught at the first edge after release
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_armed_q <= `FIFO_ARMED_RST;
      mode_q <= fifo_pkg::MODE_STANDARD;
    end else if (mode_armed_q) begin
      mode_armed_q <= 1'b0;
      // later changes of the strap are not seen
      mode_q <= mode_endian_select ? fifo_pkg::MODE_STANDARD
                                   : fifo_pkg::MODE_FALL_THROUGH;
    end
  end

  always_comb begin
    case (mode_q)
      fifo_pkg::MODE_FALL_THROUGH: fall_through_mode = 1'b1;
      fifo_pkg::MODE_STANDARD: fall_through_mode = 1'b0;
      default: fall_through_mode = 1'b0;
    endcase
  end

  // ==========================================================
  // pin drive enables; mailbox data is not carried here
  assign a_data_oe = ~port_a_ctrl.select_n & ~port_a_ctrl.dir;
  assign a_data_out = `FIFO_OUT_RST;
  assign b_data_oe = ~port_b_ctrl.select_n & port_b_ctrl.dir;
  assign b_data_out = out_q;

  // ==========================================================
  // port A write qualification; strobe gates everything
  assign wr_try = ~port_a_ctrl.select_n & port_a_ctrl.dir
                & port_a_ctrl.strobe & ~port_a_ctrl.mail_sel;
  assign wr_en = wr_try & full_inready_flag;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_ptr_q[ADDR_W-1:0]] <= a_data_in;
    end
  end

  // gray copy moves with the binary pointer, no extra delay
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr_q <= `FIFO_PTR_RST;
      wr_gray_q <= `FIFO_PTR_RST;
    end else if (wr_en) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      wr_gray_q <= to_gray(wr_ptr_q + 1'b1);
    end
  end

  // ==========================================================
  // pointer synchronisers, kept even though clocks are shared
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_gray_s1_q <= `FIFO_PTR_RST;
      wr_gray_s2_q <= `FIFO_PTR_RST;
      rd_gray_s1_q <= `FIFO_PTR_RST;
      rd_gray_s2_q <= `FIFO_PTR_RST;
    end else begin
      wr_gray_s1_q <= wr_gray_q;
      wr_gray_s2_q <= wr_gray_s1_q;
      rd_gray_s1_q <= rd_gray_q;
      rd_gray_s2_q <= rd_gray_s1_q;
    end
  end

  assign wr_seen = from_gray(wr_gray_s2_q);
  assign rd_seen = from_gray(rd_gray_s2_q);

  // ==========================================================
  // fill levels; the output word is already out of memory
  assign cnt_a = wr_ptr_q - rd_seen;
  assign cnt_b = wr_seen - rd_ptr_q;
  assign af_level = DEPTH_W - almost_full_offset;
  assign mem_has = (cnt_b != '0);

  assign full_inready_flag = (cnt_a != DEPTH_W);
  assign almost_full_flag = (cnt_a < af_level);
  assign almost_empty_flag = (cnt_b > almost_empty_offset);
  assign empty_outready_flag = fall_through_mode ? oready_q : mem_has;

  // ==========================================================
  // port B read qualification and output register load
  assign rd_try = ~port_b_ctrl.select_n & port_b_ctrl.dir
                & port_b_ctrl.strobe & ~port_b_ctrl.mail_sel;

  always_comb begin
    load = 1'b0;
    oready_d = oready_q;
    if (fall_through_mode) begin
      // idle ready flag pulls the next word by itself
      if (!oready_q || rd_try) begin
        load = mem_has;
        oready_d = mem_has;
      end
    end else begin
      load = rd_try & mem_has;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      oready_q <= `FIFO_OREADY_RST;
    end else begin
      oready_q <= oready_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_q <= `FIFO_OUT_RST;
    end else if (load) begin
      out_q <= mem[rd_ptr_q[ADDR_W-1:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_ptr_q <= `FIFO_PTR_RST;
      rd_gray_q <= `FIFO_PTR_RST;
    end else if (load) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
      rd_gray_q <= to_gray(rd_ptr_q + 1'b1);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_write_into_empty;
    !mode_armed_q && wr_en && (wr_ptr_q == rd_ptr_q) && !oready_q;
  endsequence

  sequence s_free_full;
    !mode_armed_q && !full_inready_flag && load;
  endsequence

  AST_A_DRIVE: assert property (a_data_oe |->
    !port_a_ctrl.select_n && !port_a_ctrl.dir)
    else $error("port A driven while not selected for read");

  AST_B_DRIVE: assert property (b_data_oe |->
    !port_b_ctrl.select_n && port_b_ctrl.dir)
    else $error("port B driven while not selected for read");

  AST_WRITE_STEP: assert property (wr_en |=>
    wr_ptr_q == $past(wr_ptr_q) + 1'b1)
    else $error("write pointer did not step once");

  AST_FULL_BLOCKS: assert property (
    (wr_try && !full_inready_flag) |=> $stable(wr_ptr_q))
    else $error("write taken while full");

  AST_READ_STEP: assert property (
    (load && !$past(load)) |=> rd_ptr_q == $past(rd_ptr_q) + 1'b1)
    else $error("read pointer did not step per load");

  AST_STD_IGNORED: assert property (
    (!fall_through_mode && rd_try && !empty_outready_flag) |=>
      $stable(rd_ptr_q) && $stable(b_data_out))
    else $error("standard read taken while empty");

  AST_STD_EMPTY_LAT: assert property (
    (s_write_into_empty and !fall_through_mode) |->
      !empty_outready_flag [*3] ##1 empty_outready_flag)
    else $error("empty flag latency not two edges");

  AST_FALL_THROUGH_MODE_READY_LAT: assert property (
    (s_write_into_empty and fall_through_mode) |->
      !empty_outready_flag [*4] ##1 (empty_outready_flag && load == 1'b0
        ? b_data_out == $past(a_data_in, 4) : empty_outready_flag))
    else $error("output ready latency not three edges");

  AST_FULL_RELEASE: assert property (s_free_full |->
    !full_inready_flag [*3] ##1 full_inready_flag)
    else $error("full flag release not at second edge");

endmodule
`default_nettype wire

// ==== dv/b_reader.sv ====
// Purpose: port B consumer model for the flagged queue
// Assumes: drives its controls on the falling edge of mclk
// Notes: slow mode leaves every other cycle without a strobe
`timescale 1ns/1ps
`default_nettype none
module b_reader (
  input wire logic mclk, // port clock
  input wire logic rd_en, // reads wanted
  input wire logic slow, // stall on alternate cycles
  input wire logic [1:0] junk, // noise for idle select lines
  output var fifo_pkg::port_ctrl_t ctrl // port B controls
);
  logic odd_q = 1'h0;

  // ==========================================================
  // controls
  initial ctrl = 4'h8;
  // idle keeps strobe low so wandering selects must start nothing
  always @(negedge mclk) begin
    odd_q <= ~odd_q;
    if (rd_en && !(slow && odd_q)) begin
      ctrl <= 4'h6;
    end else begin
      ctrl <= {junk, 2'h0};
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the flagged queue
// Assumes: one clock, port B worked by b_reader
// Notes: standard mode first, then fall-through after a reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic mode = 1'h1;
  logic rd_en = 1'h0;
  logic slow = 1'h0;
  fifo_pkg::port_ctrl_t a_ctrl = 4'h8;
  fifo_pkg::port_ctrl_t b_ctrl;
  logic [35:0] a_drv = 36'h0;
  logic [35:0] a_in, a_out, b_out;
  logic [35:0] exp_b = 36'h0;
  logic [8:0] x_off = 9'h8;
  logic [8:0] y_off = 9'h8;
  logic a_oe, b_oe, full, af, eo, ae, fp, rp;
  logic [15:0] r = 16'h11e6;
  logic [35:0] q[$];
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  // ==========================================================
  // wiring
  assign a_in = a_oe ? a_out : a_drv; // pin level from both drivers
  dual_clock_fifo_port_flags dut (
    .mclk(mclk), .reset_n(reset_n), .port_a_ctrl(a_ctrl),
    .a_data_in(a_in), .a_data_out(a_out), .a_data_oe(a_oe),
    .port_b_ctrl(b_ctrl), .b_data_out(b_out), .b_data_oe(b_oe),
    .mode_endian_select(mode), .almost_empty_offset(x_off),
    .almost_full_offset(y_off), .full_inready_flag(full),
    .almost_full_flag(af), .empty_outready_flag(eo),
    .almost_empty_flag(ae));
  b_reader partner (.mclk(mclk), .rd_en(rd_en), .slow(slow),
    .junk(a_drv[1:0]), .ctrl(b_ctrl));

  initial forever #25 mclk = ~mclk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task chk(input string n, input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask

  task wrap_up();
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // monitors
  // a hang is cut short well past the under one thousand cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  // model queue follows qualified writes; pre-edge values sampled
  always @(posedge mclk) begin
    if (reset_n === 1'h1 && a_ctrl === 4'h6 && full === 1'h1) begin
      q.push_back(a_in);
    end
    rp = (b_ctrl === 4'h6);
    fp = eo;
    chk("a_oe", a_oe, !a_ctrl.select_n && !a_ctrl.dir);
    chk("b_oe", b_oe, !b_ctrl.select_n && b_ctrl.dir);
    chk("a_out", a_out, 36'h0);
  end
  // output register loads only when the mode says so, else holds
  always @(negedge mclk) begin
    if (reset_n && (mode ? rp && fp : eo && (!fp || rp))) begin
      exp_b = q.pop_front();
      chk("b_load", b_out, exp_b);
    end else if (reset_n) begin
      chk("b_hold", b_out, exp_b);
    end
  end

  // ==========================================================
  // stimulus tasks
  task idle();
    @(negedge mclk);
    r = lfsr(r);
    a_ctrl <= {r[0], r[1], r[2], r[2] | r[3]};
    a_drv <= ~a_drv;
  endtask

  task wrr();
    r = lfsr(r);
    @(negedge mclk);
    a_ctrl <= 4'h6;
    a_drv <= {r[3:0], r, ~r};
    @(posedge mclk);
  endtask

  task reset_to(input logic m);
    @(negedge mclk);
    r = lfsr(r);
    rd_en <= 1'h0;
    reset_n <= 1'h0;
    mode <= m;
    x_off <= {3'h0, r[5:0]} + 9'h1;
    y_off <= {3'h0, r[11:6]} + 9'h1;
    repeat (8) idle();
    // cleared only once reset has landed in the output register
    q.delete();
    exp_b = 36'h0;
    reset_n <= 1'h1;
    idle();
    chk("rst_flags", {full, af, eo, ae}, 4'hc);
  endtask

  task lat(input logic f, input int n);
    for (int i = 0; i <= n; i++) begin
      idle();
      chk("flag_lat", f ? full : eo, i == n);
    end
  endtask

  task drain(input logic s);
    @(negedge mclk);
    slow <= s;
    rd_en <= 1'h1;
    for (int i = 0; i < 2000 && q.size() > 0; i++) idle();
    rd_en <= 1'h0;
    chk("drained", q.size(), 0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_to(1'h1);
    rd_en <= 1'h1;
    wrr();
    lat(1'h0, 2);
    drain(1'h0);
    for (int i = 1; i <= 256; i++) begin
      wrr();
      if (i == x_off || i == x_off + 1 || i >= 255 - y_off &&
          i <= 256 - y_off) begin
        repeat (3) idle();
        chk("ae", ae, i > x_off);
        chk("af", af, i < 256 - y_off);
      end
    end
    repeat (3) idle();
    chk("full", full, 1'h0);
    wrr();
    repeat (2) idle();
    @(posedge mclk) rd_en <= 1'h1;
    @(posedge mclk) rd_en <= 1'h0;
    lat(1'h1, 2);
    drain(1'h1);
    reset_to(1'h0);
    wrr();
    lat(1'h0, 3);
    rd_en <= 1'h1;
    repeat (6) wrr();
    drain(1'h1);
    // one more read on an empty memory must drop output-ready
    rd_en <= 1'h1;
    repeat (3) idle();
    rd_en <= 1'h0;
    repeat (2) idle();
    chk("out_ready", eo, 1'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
